/* src/overload_pkg.sv */
// constants, register map and field layouts for the current overload limiter
// assumes a 32-bit apb slave at a 20 mhz system clock
package overload_pkg;
  localparam int CLK_HZ = 20_000_000;
  localparam int TICK_TIME_MS = 1;
  // cycles per millisecond integration step
  localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_TIME_MS;
  localparam int TICK_W = 16;
  localparam int ACC_W = 32;
  localparam int CUR_W = 16;

  localparam logic [7:0] ADDR_MAX_MOTOR_CURRENT = 8'h00;
  localparam logic [7:0] ADDR_RATED_CURRENT = 8'h04;
  localparam logic [7:0] ADDR_PEAK_PERMILLE = 8'h08;
  localparam logic [7:0] ADDR_PEAK_DURATION = 8'h0C;
  localparam logic [7:0] ADDR_THRESHOLD = 8'h10;
  localparam logic [7:0] ADDR_ACCUMULATOR = 8'h14;
  localparam logic [7:0] ADDR_APPLIED_LIMIT = 8'h18;
  localparam logic [7:0] ADDR_STATUS = 8'h1C;
  localparam logic [7:0] ADDR_DRIVE_SUBMODE = 8'h20;
  localparam logic [7:0] ADDR_MEASURED = 8'h24;

  localparam int SUBMODE_CLOSED_LOOP_BIT = 0;

  localparam logic [15:0] RST_MAX_MOTOR_CURRENT = 16'h0000;
  localparam logic [15:0] RST_RATED_CURRENT = 16'h0000;
  localparam logic [15:0] RST_PEAK_PERMILLE = 16'h03E8;
  localparam logic [15:0] RST_PEAK_DURATION = 16'h0000;
  localparam logic [31:0] RST_SUBMODE = 32'h0000_0000;
  localparam logic [15:0] PERMILLE_FULL = 16'h03E8;
endpackage

/* src/overload_tick.sv */
// millisecond tick generator for the overload integrator
// assumes a synchronous active-low reset from the top
`timescale 1ns/1ps
module overload_tick #(
  parameter int CYCLES = overload_pkg::TICK_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  output logic o_tick
);
  import overload_pkg::*;
  logic [TICK_W-1:0] count_reg;

  // free running divider, one pulse per period
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      count_reg <= '0;
      o_tick <= 1'b0;
    end else if (count_reg == TICK_W'(CYCLES - 1)) begin
      count_reg <= '0;
      o_tick <= 1'b1;
    end else begin
      count_reg <= count_reg + 1'b1;
      o_tick <= 1'b0;
    end
  end
endmodule

/* src/overload_calc.sv */
// limit derivation: threshold and per-step squared-current terms
// assumes stable configuration inputs; result is registered
`timescale 1ns/1ps
module overload_calc (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [15:0] i_rated_ma,
  input wire logic [15:0] i_peak_permille,
  input wire logic [15:0] i_duration_ms,
  input wire logic [15:0] i_max_motor_ma,
  input wire logic [15:0] i_measured_ma,
  output logic [15:0] o_peak_ma,
  output logic [31:0] o_threshold,
  output logic [31:0] o_meas_sq,
  output logic [31:0] o_rated_sq
);
  import overload_pkg::*;
  logic [31:0] peak_wide;
  logic [15:0] peak_ma;
  logic [31:0] excess_sq;

  // peak in ma from permille of rated, clipped by motor maximum
  always_comb begin
    peak_wide = (32'(i_rated_ma) * 32'(i_peak_permille)) / 32'(PERMILLE_FULL);
    peak_ma = (peak_wide > 32'(i_max_motor_ma)) ? i_max_motor_ma
                                               : peak_wide[15:0];
    excess_sq = 32'(peak_ma) * 32'(peak_ma) - 32'(i_rated_ma) * 32'(i_rated_ma);
  end

  // squares are in ma^2; dividing by 1e6 gives a^2 per ms step
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_peak_ma <= '0;
      o_threshold <= '0;
      o_meas_sq <= '0;
      o_rated_sq <= '0;
    end else begin
      o_peak_ma <= peak_ma;
      o_threshold <= 32'((64'(excess_sq) * 64'(i_duration_ms))
                         / 64'd1000000);
      o_meas_sq <= (32'(i_measured_ma) * 32'(i_measured_ma)) / 32'd1000000;
      o_rated_sq <= (32'(i_rated_ma) * 32'(i_rated_ma)) / 32'd1000000;
    end
  end
endmodule

/* src/motor_overload_current_limiter.sv */
// i2t overload limiter with apb register access
// assumes measured current arrives from the current controller on i_clk
`timescale 1ns/1ps
module motor_overload_current_limiter (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic [15:0] i_measured_ma,
  output logic [15:0] o_applied_current_limit,
  output logic o_limiter_active
);
  import overload_pkg::*;

  typedef enum logic [2:0] {
    ST_OFF = 3'b001,
    ST_PEAK = 3'b010,
    ST_CLAMP = 3'b100
  } limit_state_t;

  logic rst_s1_reg;
  logic rst_n;
  logic [15:0] max_motor_reg;
  logic [15:0] rated_reg;
  logic [15:0] peak_permille_reg;
  logic [15:0] peak_duration_ms;
  logic [31:0] submode_reg;
  logic [31:0] overload_accumulator;
  limit_state_t state_reg;
  logic tick;
  logic [15:0] peak_ma;
  logic [31:0] threshold;
  logic [31:0] meas_sq;
  logic [31:0] rated_sq;
  logic enabled;
  logic access;
  logic [31:0] rd_data;
  logic rd_hit;

  // byte-lane merge for a 16-bit register in the low half
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0] strb);
    merge16 = old;
    if (strb[0]) begin
      merge16[7:0] = wd[7:0];
    end
    if (strb[1]) begin
      merge16[15:8] = wd[15:8];
    end
  endfunction

  // reset release through two flops, assertion stays asynchronous
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rst_s1_reg <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_n <= rst_s1_reg;
    end
  end

  overload_tick #(
    .CYCLES(TICK_CYCLES)
  ) u_tick (
    .i_clk(i_clk),
    .i_rst_n(rst_n),
    .o_tick(tick)
  );

  overload_calc u_calc (
    .i_clk(i_clk),
    .i_rst_n(rst_n),
    .i_rated_ma(rated_reg),
    .i_peak_permille(peak_permille_reg),
    .i_duration_ms(peak_duration_ms),
    .i_max_motor_ma(max_motor_reg),
    .i_measured_ma(i_measured_ma),
    .o_peak_ma(peak_ma),
    .o_threshold(threshold),
    .o_meas_sq(meas_sq),
    .o_rated_sq(rated_sq)
  );

  // enable needs closed loop, peak above rated and a duration
  assign enabled = submode_reg[SUBMODE_CLOSED_LOOP_BIT]
                   && (peak_ma > rated_reg)
                   && (peak_duration_ms != 16'h0000);

  assign access = i_psel && i_penable && o_pready;

  // configuration writes, taken in the access phase only
  always_ff @(posedge i_clk) begin
    if (!rst_n) begin
      max_motor_reg <= RST_MAX_MOTOR_CURRENT;
      rated_reg <= RST_RATED_CURRENT;
      peak_permille_reg <= RST_PEAK_PERMILLE;
      peak_duration_ms <= RST_PEAK_DURATION;
      submode_reg <= RST_SUBMODE;
    end else if (access && i_pwrite) begin
      unique case (i_paddr)
        ADDR_MAX_MOTOR_CURRENT: begin
          max_motor_reg <= merge16(max_motor_reg, i_pwdata, i_pstrb);
        end
        ADDR_RATED_CURRENT: begin
          rated_reg <= merge16(rated_reg, i_pwdata, i_pstrb);
        end
        ADDR_PEAK_PERMILLE: begin
          peak_permille_reg <= merge16(peak_permille_reg, i_pwdata, i_pstrb);
        end
        ADDR_PEAK_DURATION: begin
          peak_duration_ms <= merge16(peak_duration_ms, i_pwdata, i_pstrb);
        end
        ADDR_DRIVE_SUBMODE: begin
          submode_reg[7:0] <= i_pstrb[0] ? i_pwdata[7:0] : submode_reg[7:0];
        end
        default: begin
        end
      endcase
    end
  end

  // integrator: adds i^2 minus rated^2 each ms, never below zero
  always_ff @(posedge i_clk) begin
    if (!rst_n) begin
      overload_accumulator <= '0;
    end else if (!enabled) begin
      overload_accumulator <= '0;
    end else if (tick) begin
      if (meas_sq >= rated_sq) begin
        // saturate so a long overload cannot wrap to a small value
        overload_accumulator <= (overload_accumulator > ~(meas_sq - rated_sq))
                                ? 32'hFFFF_FFFF
                                : overload_accumulator + (meas_sq - rated_sq);
      end else if (overload_accumulator > (rated_sq - meas_sq)) begin
        overload_accumulator <= overload_accumulator - (rated_sq - meas_sq);
      end else begin
        overload_accumulator <= '0;
      end
    end
  end

  // limit selection against the threshold
  always_ff @(posedge i_clk) begin
    if (!rst_n) begin
      state_reg <= ST_OFF;
    end else if (!enabled) begin
      state_reg <= ST_OFF;
    end else begin
      unique case (state_reg)
        ST_OFF: begin
          state_reg <= ST_PEAK;
        end
        ST_PEAK: begin
          if (overload_accumulator >= threshold) begin
            state_reg <= ST_CLAMP;
          end
        end
        ST_CLAMP: begin
          if (overload_accumulator < threshold) begin
            state_reg <= ST_PEAK;
          end
        end
        default: begin
          state_reg <= ST_OFF;
        end
      endcase
    end
  end

  // applied limit and active flag; when off the rated value applies
  always_ff @(posedge i_clk) begin
    if (!rst_n) begin
      o_applied_current_limit <= '0;
      o_limiter_active <= 1'b0;
    end else begin
      o_limiter_active <= (state_reg != ST_OFF);
      if (state_reg == ST_PEAK) begin
        o_applied_current_limit <= peak_ma;
      end else begin
        o_applied_current_limit <= rated_reg;
      end
    end
  end

  // read decode; unmapped addresses answer with an error
  always_comb begin
    rd_data = 32'h0000_0000;
    rd_hit = 1'b1;
    unique case (i_paddr)
      ADDR_MAX_MOTOR_CURRENT: rd_data = {16'h0000, max_motor_reg};
      ADDR_RATED_CURRENT: rd_data = {16'h0000, rated_reg};
      ADDR_PEAK_PERMILLE: rd_data = {16'h0000, peak_permille_reg};
      ADDR_PEAK_DURATION: rd_data = {16'h0000, peak_duration_ms};
      ADDR_THRESHOLD: rd_data = threshold;
      ADDR_ACCUMULATOR: rd_data = overload_accumulator;
      ADDR_APPLIED_LIMIT: rd_data = {16'h0000, o_applied_current_limit};
      ADDR_STATUS: rd_data = {31'h0000_0000, o_limiter_active};
      ADDR_DRIVE_SUBMODE: rd_data = {24'h00_0000, submode_reg[7:0]};
      ADDR_MEASURED: rd_data = {16'h0000, i_measured_ma};
      default: rd_hit = 1'b0;
    endcase
  end

  // no wait state: ready rises in the first access cycle
  always_ff @(posedge i_clk) begin
    if (!rst_n) begin
      o_pready <= 1'b0;
      o_prdata <= '0;
      o_pslverr <= 1'b0;
    end else if (i_psel && !i_penable) begin
      o_pready <= 1'b1;
      o_prdata <= i_pwrite ? 32'h0000_0000 : rd_data;
      o_pslverr <= !rd_hit;
    end else begin
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
    end
  end
endmodule

/* verification/overload_properties.sv */
// port-level assertions for the overload limiter, bound to its top
// assumes the apb master never drops a request before pready
`timescale 1ns/1ps
module overload_properties
  import overload_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire logic [15:0] o_applied_current_limit,
  input wire logic o_limiter_active
);
  logic [15:0] rated_sh;
  logic [15:0] max_sh;
  logic loop_sh;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  // config shadows so limits can be judged without internal taps
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rated_sh <= 16'h0000;
      max_sh <= 16'h0000;
      loop_sh <= 1'b0;
    end else if (i_psel && i_penable && o_pready && i_pwrite) begin
      if (i_paddr == ADDR_RATED_CURRENT) rated_sh <= i_pwdata[15:0];
      if (i_paddr == ADDR_MAX_MOTOR_CURRENT) max_sh <= i_pwdata[15:0];
      if (i_paddr == ADDR_DRIVE_SUBMODE) loop_sh <= i_pwdata[0];
    end
  end
  sequence setup_s;
    i_psel && !i_penable;
  endsequence
  sequence bad_addr_s;
    setup_s ##0 (i_paddr > 8'h24 || i_paddr[1:0] != 2'b00);
  endsequence
  pready_pulse_a: assert property (setup_s |=> o_pready)
    else $error("no pready after setup");
  pready_single_a: assert property (o_pready |=> !o_pready)
    else $error("pready longer than one cycle");
  pslverr_pair_a: assert property (o_pslverr |-> o_pready)
    else $error("error without pready");
  unmapped_err_a: assert property (bad_addr_s |=> o_pslverr)
    else $error("unmapped access not refused");
  inactive_rated_a: assert property (
    (!o_limiter_active && $stable(rated_sh))[*5]
    |-> o_applied_current_limit == rated_sh)
    else $error("inactive limit differs from rated");
  max_bound_a: assert property (
    (o_limiter_active && $stable(max_sh))[*5]
    |-> o_applied_current_limit <= max_sh)
    else $error("limit above maximum motor current");
  closed_loop_a: assert property ((!loop_sh)[*4] |-> !o_limiter_active)
    else $error("limiter active without closed loop");
  reset_quiet_a: assert property ($rose(i_arst_n) |->
    !o_limiter_active ##1 !o_limiter_active)
    else $error("limiter active right after reset");
endmodule
bind motor_overload_current_limiter overload_properties u_props (
  .i_clk(i_clk),
  .i_arst_n(i_arst_n),
  .i_psel(i_psel),
  .i_penable(i_penable),
  .i_pwrite(i_pwrite),
  .i_paddr(i_paddr),
  .i_pwdata(i_pwdata),
  .o_pready(o_pready),
  .o_pslverr(o_pslverr),
  .o_applied_current_limit(o_applied_current_limit),
  .o_limiter_active(o_limiter_active)
);

/* verification/current_loop_model.sv */
// current loop stand-in feeding the measured current back
// assumes demand from the bench; never exceeds the applied limit of one cycle earlier
`timescale 1ns/1ps
module current_loop_model (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic [15:0] i_demand_ma,
  input wire logic [15:0] i_limit_ma,
  output logic [15:0] o_measured_ma
);
  // one cycle of loop lag; demand above the limit is cut to the limit
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) o_measured_ma <= 16'h0000;
    else if (i_demand_ma > i_limit_ma) o_measured_ma <= i_limit_ma;
    else o_measured_ma <= i_demand_ma;
  end
endmodule

/* verification/tb.sv */
// self-checking bench for the overload limiter over apb
// assumes no wait state per transfer and a 1 ms integration step
`timescale 1ns/1ps
module tb;
  import overload_pkg::*;
  logic i_clk, i_arst_n, psel, penable, pwrite, pready, pslverr, active;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [15:0] demand, meas, limit;
  logic [32:0] exp_q[$];
  int error_cnt = 0, checks = 0, seed = 32'h9d72f408, n;
  motor_overload_current_limiter DUT (.i_clk(i_clk), .i_arst_n(i_arst_n),
    .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(4'hf),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_measured_ma(meas), .o_applied_current_limit(limit),
    .o_limiter_active(active));
  current_loop_model u_loop (.i_clk(i_clk), .i_arst_n(i_arst_n),
    .i_demand_ma(demand), .i_limit_ma(limit), .o_measured_ma(meas));
  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end
  task automatic check(input string nm, input logic [32:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // read results are compared in order against the noted expectations
  always @(posedge i_clk) begin
    if (psel && penable && pready && !pwrite)
      check("read", {pslverr, prdata}, exp_q.pop_front());
  end
  // request held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge i_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    // a missing pready is a mismatch; the run closes without releasing
    if (pready !== 1'b1) begin
      check("pready", 33'h0, 33'h1);
      end_of_test();
    end else begin
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge i_clk);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    exp_q.push_back(e);
    apb(1'b0, a, 32'h0000_0000);
  endtask
  task automatic wait_lim(input logic [15:0] v, input int lim);
    n = 0;
    while (limit !== v && n < lim) begin
      @(posedge i_clk);
      n++;
    end
    check("limit", 33'(limit), 33'(v));
    if (limit !== v) end_of_test();
  endtask
  initial begin
    {psel, penable, pwrite, paddr, pwdata, demand} = '0;
    i_arst_n = 1'b0;
    repeat (10) @(posedge i_clk);
    i_arst_n <= 1'b1;
    repeat (3) @(posedge i_clk);
    rd(ADDR_PEAK_PERMILLE, 33'(RST_PEAK_PERMILLE));
    apb(1'b1, 8'h28, 32'h0000_00ff);
    rd(8'h28, 33'h1_0000_0000);
    rd(8'h02, 33'h1_0000_0000);
    $display("reset test done");
    // peak capped at 1500 ma: (1500^2-1000^2)*4/1e6 = 5
    apb(1'b1, ADDR_RATED_CURRENT, 32'h0000_03e8);
    apb(1'b1, ADDR_MAX_MOTOR_CURRENT, 32'h0000_05dc);
    apb(1'b1, ADDR_PEAK_PERMILLE, 32'h0000_07d0);
    apb(1'b1, ADDR_PEAK_DURATION, 32'h0000_0004);
    demand <= 16'($unsigned($random(seed)) % 1000);
    rd(ADDR_STATUS, 33'h0);
    apb(1'b1, ADDR_DRIVE_SUBMODE, 32'h0000_0001);
    rd(ADDR_DRIVE_SUBMODE, 33'h1);
    repeat (6) @(posedge i_clk);
    apb(1'b1, ADDR_THRESHOLD, $random(seed));
    rd(ADDR_THRESHOLD, 33'h5);
    rd(ADDR_APPLIED_LIMIT, 33'h5dc);
    rd(ADDR_ACCUMULATOR, 33'h0);
    rd(ADDR_STATUS, 33'h1);
    $display("peak cap test done");
    // peak not above rated, then no duration: limiter stays off
    apb(1'b1, ADDR_PEAK_PERMILLE, 32'h0000_03e8);
    repeat (6) @(posedge i_clk);
    rd(ADDR_STATUS, 33'h0);
    apb(1'b1, ADDR_PEAK_PERMILLE, 32'h0000_07d0);
    apb(1'b1, ADDR_PEAK_DURATION, 32'h0000_0000);
    repeat (6) @(posedge i_clk);
    rd(ADDR_APPLIED_LIMIT, 33'h3e8);
    $display("inactive test done");
    // 2000 ma for 2 ms: threshold 6, three added per step
    apb(1'b1, ADDR_MAX_MOTOR_CURRENT, 32'h0000_0bb8);
    apb(1'b1, ADDR_PEAK_DURATION, 32'h0000_0002);
    repeat (6) @(posedge i_clk);
    rd(ADDR_THRESHOLD, 33'h6);
    demand <= 16'h07d0;
    wait_lim(16'h03e8, 61000);
    check("late", 33'(n >= 19000), 33'h1);
    check("active", 33'(active), 33'h1);
    rd(ADDR_ACCUMULATOR, 33'h6);
    rd(ADDR_MEASURED, 33'h3e8);
    demand <= 16'h0000;
    wait_lim(16'h07d0, 21000);
    rd(ADDR_ACCUMULATOR, 33'h5);
    apb(1'b1, ADDR_DRIVE_SUBMODE, 32'h0000_0000);
    repeat (6) @(posedge i_clk);
    rd(ADDR_ACCUMULATOR, 33'h0);
    $display("overload test done");
    end_of_test();
  end
endmodule
